// ==== logic/dofs_pkg.sv ====
package dofs_pkg;

   localparam int CODE_W = 16;

   // Parameter address of the output 0 function code
   localparam logic [15:0] ADDR_OUTPUT0_FUNCTION_CODE = 16'h0712;

   // Reset selection: No Fault
   localparam logic [CODE_W-1:0] CODE_RESET = 16'h0002;

   localparam logic [CODE_W-1:0] CODE_FREE = 16'h0001;
   localparam logic [CODE_W-1:0] CODE_NO_FAULT = 16'h0002;
   localparam logic [CODE_W-1:0] CODE_ACTIVE = 16'h0003;
   localparam logic [CODE_W-1:0] CODE_REL_MOVE = 16'h0004;
   localparam logic [CODE_W-1:0] CODE_POS_WINDOW = 16'h0005;
   localparam logic [CODE_W-1:0] CODE_VEL_WINDOW = 16'h0006;
   localparam logic [CODE_W-1:0] CODE_VEL_BELOW = 16'h0007;
   localparam logic [CODE_W-1:0] CODE_CUR_BELOW = 16'h0008;
   localparam logic [CODE_W-1:0] CODE_HALT_ACK = 16'h0009;
   localparam logic [CODE_W-1:0] CODE_SEQ_START_ACK = 16'h000b;
   localparam logic [CODE_W-1:0] CODE_STANDSTILL = 16'h000d;
   localparam logic [CODE_W-1:0] CODE_SEL_ERROR = 16'h000e;
   localparam logic [CODE_W-1:0] CODE_REF_VALID = 16'h000f;
   localparam logic [CODE_W-1:0] CODE_SEL_WARNING = 16'h0010;
   localparam logic [CODE_W-1:0] CODE_SEQ_DONE = 16'h0011;
   localparam logic [CODE_W-1:0] CODE_POSREG_CH1 = 16'h0012;
   localparam logic [CODE_W-1:0] CODE_POSREG_CH2 = 16'h0013;
   localparam logic [CODE_W-1:0] CODE_POSREG_CH4 = 16'h0015;
   localparam logic [CODE_W-1:0] CODE_MOVES_POS = 16'h0016;
   localparam logic [CODE_W-1:0] CODE_MOVES_NEG = 16'h0017;

   // Status flags from the motion controller, all on ref_clk_i
   typedef struct packed {
      logic ready_to_switch_on;
      logic switched_on;
      logic operation_enabled;
      logic relative_move_after_capture;
      logic pos_dev_in_window;
      logic vel_dev_in_window;
      logic vel_below_threshold;
      logic cur_below_threshold;
      logic halt_ack;
      logic seq_start_ack;
      logic standstill;
      logic selected_error;
      logic ref_valid;
      logic selected_warning;
      logic seq_done;
      logic posreg_ch1;
      logic posreg_ch2;
      logic posreg_ch4;
      logic moves_positive;
      logic moves_negative;
   } dofs_status_t;

   // Parameter access request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [15:0] addr;
      logic [CODE_W-1:0] wdata;
   } dofs_req_t;

   // Parameter access answer
   typedef struct packed {
      logic ack;
      logic reject;
      logic [CODE_W-1:0] rdata;
   } dofs_rsp_t;

endpackage

// ==== logic/dofs_func_mux.sv ====
`timescale 1ns/1ps
module dofs_func_mux (
   input wire logic [dofs_pkg::CODE_W-1:0] code_i,
   input wire dofs_pkg::dofs_status_t status_i,
   input wire logic free_value_i,
   output logic level_o,
   output logic code_valid_o
);

   always_comb begin
      level_o = 1'b0;
      code_valid_o = 1'b1;
      case (code_i)
         dofs_pkg::CODE_FREE: level_o = free_value_i;
         dofs_pkg::CODE_NO_FAULT: level_o = status_i.ready_to_switch_on | status_i.switched_on
                                            | status_i.operation_enabled;
         dofs_pkg::CODE_ACTIVE: level_o = status_i.operation_enabled;
         dofs_pkg::CODE_REL_MOVE: level_o = status_i.relative_move_after_capture;
         dofs_pkg::CODE_POS_WINDOW: level_o = status_i.pos_dev_in_window;
         dofs_pkg::CODE_VEL_WINDOW: level_o = status_i.vel_dev_in_window;
         dofs_pkg::CODE_VEL_BELOW: level_o = status_i.vel_below_threshold;
         dofs_pkg::CODE_CUR_BELOW: level_o = status_i.cur_below_threshold;
         dofs_pkg::CODE_HALT_ACK: level_o = status_i.halt_ack;
         dofs_pkg::CODE_SEQ_START_ACK: level_o = status_i.seq_start_ack;
         dofs_pkg::CODE_STANDSTILL: level_o = status_i.standstill;
         dofs_pkg::CODE_SEL_ERROR: level_o = status_i.selected_error;
         dofs_pkg::CODE_REF_VALID: level_o = status_i.ref_valid;
         dofs_pkg::CODE_SEL_WARNING: level_o = status_i.selected_warning;
         dofs_pkg::CODE_SEQ_DONE: level_o = status_i.seq_done;
         dofs_pkg::CODE_POSREG_CH1: level_o = status_i.posreg_ch1;
         dofs_pkg::CODE_POSREG_CH2: level_o = status_i.posreg_ch2;
         dofs_pkg::CODE_POSREG_CH4: level_o = status_i.posreg_ch4;
         dofs_pkg::CODE_MOVES_POS: level_o = status_i.moves_positive;
         dofs_pkg::CODE_MOVES_NEG: level_o = status_i.moves_negative;
         default: code_valid_o = 1'b0;
      endcase
   end

endmodule

// ==== logic/dofs_output0_select.sv ====
`timescale 1ns/1ps
// Overview of operation
// - Code 1 drives output 0 from the free software value.
// - Code 2 asserts while ready-to-switch-on, switched-on or operation-enabled.
// - Code 3 asserts only while operation-enabled.
// - Code 4 asserts while relative move after capture is active or finished.
// - Codes 5 and 6 assert inside position or velocity deviation windows.
// - Codes 7 and 8 assert while velocity or current is below threshold.
// - Code 9 drives the halt acknowledgement.
// - Code 11 drives the motion sequence start acknowledgement.
// - Code 13 asserts while the motor stands still.
// - Code 14 asserts while a selected error of classes 1 to 4 is active.
// - Code 15 asserts while the homing zero point is valid.
// - Code 16 asserts while a selected warning (class 0) is active.
// - Code 17 asserts when the motion sequence is done.
// - Codes 18, 19, 21 route position register channels 1, 2, 4.
// - Codes 22 and 23 show positive and negative movement direction.
// - Code writes are refused while the power stage is enabled.
// - A new code is stored but used only after the next power-on.
// - On a detected error the output keeps following its function.
module dofs_output0_select (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic ce_i,
   input wire logic power_up_i,
   input wire logic power_stage_en_i,
   input wire logic free_value_i,
   input wire dofs_pkg::dofs_status_t status_i,
   input wire dofs_pkg::dofs_req_t req_i,
   output dofs_pkg::dofs_rsp_t rsp_o,
   output logic [dofs_pkg::CODE_W-1:0] active_code_o,
   output logic digital_output_0_o
);

   typedef struct packed {
      logic [dofs_pkg::CODE_W-1:0] stored_code;
      logic [dofs_pkg::CODE_W-1:0] active_code;
      dofs_pkg::dofs_rsp_t rsp;
      logic dout;
   } dofs_state_t;

   dofs_state_t state;
   dofs_state_t next_state;

   logic sel_level;
   logic active_valid;
   logic wdata_valid;
   logic addr_hit;

   // Live selection from the code in use
   dofs_func_mux u_mux_active (
      .code_i(state.active_code),
      .status_i(status_i),
      .free_value_i(free_value_i),
      .level_o(sel_level),
      .code_valid_o(active_valid)
   );

   // Same table reused as the write validity check
   dofs_func_mux u_mux_check (
      .code_i(req_i.wdata),
      .status_i(status_i),
      .free_value_i(free_value_i),
      .level_o(),
      .code_valid_o(wdata_valid)
   );

   assign addr_hit = (req_i.addr == dofs_pkg::ADDR_OUTPUT0_FUNCTION_CODE);

   always_comb begin
      next_state = state;
      next_state.rsp.ack = 1'b0;
      next_state.rsp.reject = 1'b0;
      // No error override: output always tracks its function
      next_state.dout = sel_level & active_valid;
      if (power_up_i) begin
         next_state.active_code = state.stored_code;
      end
      if (req_i.wr) begin
         // Write wins over a simultaneous read
         if (addr_hit && !power_stage_en_i && wdata_valid) begin
            next_state.stored_code = req_i.wdata;
            next_state.rsp.ack = 1'b1;
         end else begin
            next_state.rsp.reject = 1'b1;
         end
         next_state.rsp.rdata = '0;
      end else if (req_i.rd) begin
         if (addr_hit) begin
            next_state.rsp.rdata = state.stored_code;
            next_state.rsp.ack = 1'b1;
         end else begin
            next_state.rsp.rdata = '0;
            next_state.rsp.reject = 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         state.stored_code <= dofs_pkg::CODE_RESET;
         state.active_code <= dofs_pkg::CODE_RESET;
         state.rsp <= '0;
         state.dout <= 1'b0;
      end else if (ce_i) begin
         state <= next_state;
      end
   end

   assign rsp_o = state.rsp;
   assign active_code_o = state.active_code;
   assign digital_output_0_o = state.dout;

endmodule

// ==== dv/dofs_wiring_model.sv ====
`timescale 1ns/1ps
// Controller input behind the wire; no pull on the line, so it shows the driven level only
module dofs_wiring_model (
   input wire logic level_i,
   output logic seen_o
);
   assign seen_o = level_i;
endmodule

// ==== dv/dofs_output0_select_checker.sv ====
`timescale 1ns/1ps
module dofs_output0_select_checker (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic ce_i,
   input wire logic power_up_i,
   input wire logic power_stage_en_i,
   input wire logic free_value_i,
   input wire dofs_pkg::dofs_status_t status_i,
   input wire dofs_pkg::dofs_req_t req_i,
   input wire dofs_pkg::dofs_rsp_t rsp_o,
   input wire logic [dofs_pkg::CODE_W-1:0] active_code_o,
   input wire logic digital_output_0_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (srst_i);
   sequence s_wr; ce_i && req_i.wr; endsequence
   sequence s_hit; req_i.addr == dofs_pkg::ADDR_OUTPUT0_FUNCTION_CODE; endsequence
   a_busy_reject: assert property (s_wr ##0 power_stage_en_i |=> rsp_o.reject && !rsp_o.ack)
      else $error("write during power stage not refused");
   a_addr_reject: assert property (ce_i && (req_i.wr || req_i.rd)
      && req_i.addr != dofs_pkg::ADDR_OUTPUT0_FUNCTION_CODE |=> rsp_o.reject)
      else $error("foreign address not refused");
   a_good_write: assert property (s_wr ##0 s_hit ##0 !power_stage_en_i
      && req_i.wdata inside {[1:9], 11, [13:19], [21:23]} |=> rsp_o.ack && !rsp_o.reject)
      else $error("legal write not acknowledged");
   a_idle_quiet: assert property (ce_i && !req_i.wr && !req_i.rd |=> !rsp_o.ack && !rsp_o.reject)
      else $error("answer without request");
   a_code_hold: assert property (!power_up_i |=> $stable(active_code_o))
      else $error("active code changed without power-on");
   a_ce_freeze: assert property (!ce_i |=> $stable(digital_output_0_o) && $stable(active_code_o))
      else $error("state moved with clock enable low");
   a_free_follow: assert property (ce_i && active_code_o == dofs_pkg::CODE_FREE
      |=> digital_output_0_o == $past(free_value_i))
      else $error("output not following free value");
   a_fault_follow: assert property (ce_i && active_code_o == dofs_pkg::CODE_NO_FAULT |=> digital_output_0_o
      == $past(status_i.ready_to_switch_on || status_i.switched_on || status_i.operation_enabled))
      else $error("output not following no-fault states");
   a_active_follow: assert property (ce_i && active_code_o == dofs_pkg::CODE_ACTIVE
      |=> digital_output_0_o == $past(status_i.operation_enabled))
      else $error("output not following operation enabled");
endmodule
bind dofs_output0_select dofs_output0_select_checker dofs_output0_select_checker_inst (.ref_clk_i(ref_clk_i),
   .srst_i(srst_i), .ce_i(ce_i), .power_up_i(power_up_i), .power_stage_en_i(power_stage_en_i),
   .free_value_i(free_value_i), .status_i(status_i), .req_i(req_i), .rsp_o(rsp_o),
   .active_code_o(active_code_o), .digital_output_0_o(digital_output_0_o));

// ==== dv/dofs_output0_select_tb.sv ====
`timescale 1ns/1ps
module dofs_output0_select_tb;
   localparam logic [15:0] AD = dofs_pkg::ADDR_OUTPUT0_FUNCTION_CODE;
   localparam logic [4:0] CD[20] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0b,
      5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h11, 5'h12, 5'h13, 5'h15, 5'h16, 5'h17};
   localparam logic [4:0] BI[20] = '{5'h00, 5'h12, 5'h11, 5'h10, 5'h0f, 5'h0e, 5'h0d, 5'h0c, 5'h0b, 5'h0a,
      5'h09, 5'h08, 5'h07, 5'h06, 5'h05, 5'h04, 5'h03, 5'h02, 5'h01, 5'h00};
   localparam logic [4:0] BAD[5] = '{5'h00, 5'h0a, 5'h0c, 5'h14, 5'h18};
   logic ref_clk_i = 1'b0, srst_i = 1'b1, ce_i = 1'b1, power_up_i = 1'b0, power_stage_en_i = 1'b0;
   logic free_value_i = 1'b0, seen;
   dofs_pkg::dofs_status_t status_i = '0;
   dofs_pkg::dofs_req_t req_i = '0;
   dofs_pkg::dofs_rsp_t rsp_o;
   logic [15:0] active_code_o;
   logic digital_output_0_o;
   int failures = 0, checks = 0;
   initial forever #2.5 ref_clk_i = ~ref_clk_i;
   dofs_output0_select dofs_output0_select_inst (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .ce_i(ce_i),
      .power_up_i(power_up_i), .power_stage_en_i(power_stage_en_i), .free_value_i(free_value_i),
      .status_i(status_i), .req_i(req_i), .rsp_o(rsp_o), .active_code_o(active_code_o),
      .digital_output_0_o(digital_output_0_o));
   dofs_wiring_model dofs_wiring_model_inst (.level_i(digital_output_0_o), .seen_o(seen));
   task chk(input logic [15:0] s, input logic [15:0] e);
      checks++;
      if (s !== e) begin
         failures++;
         $display("ERROR %0t seen %h expected %h", $time, s, e);
      end
   endtask
   // One request, answer looked at in its single answer cycle
   task acc(input logic w, input logic [15:0] a, input logic [15:0] d, input logic rej);
      @(negedge ref_clk_i);
      req_i = '{wr: w, rd: !w, addr: a, wdata: d};
      @(negedge ref_clk_i);
      req_i = '0;
      chk({rsp_o.ack, rsp_o.reject}, {!rej, rej});
   endtask
   task pwr;
      @(negedge ref_clk_i);
      power_up_i = 1'b1;
      @(negedge ref_clk_i);
      power_up_i = 1'b0;
   endtask
   task give_verdict;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      #200us;
      failures++;
      give_verdict;
   end
   initial begin
      repeat (20) @(negedge ref_clk_i);
      srst_i = 1'b0;
      acc(1'b0, AD, 16'h0000, 1'b0);
      chk(rsp_o.rdata, 16'h0002);
      acc(1'b1, AD, 16'h0003, 1'b0);
      chk(active_code_o, 16'h0002);
      acc(1'b0, AD, 16'h0000, 1'b0);
      chk(rsp_o.rdata, 16'h0003);
      power_stage_en_i = 1'b1;
      acc(1'b1, AD, 16'h0005, 1'b1);
      power_stage_en_i = 1'b0;
      for (int k = 0; k < 5; k++) acc(1'b1, AD, {11'h000, BAD[k]}, 1'b1);
      acc(1'b0, AD + 16'h0001, 16'h0000, 1'b1);
      acc(1'b0, AD, 16'h0000, 1'b0);
      chk(rsp_o.rdata, 16'h0003);
      for (int i = 0; i < 20; i++) begin
         acc(1'b1, AD, {11'h000, CD[i]}, 1'b0);
         pwr;
         chk(active_code_o, {11'h000, CD[i]});
         status_i = 20'h00001 << BI[i];
         free_value_i = (i == 0);
         @(negedge ref_clk_i);
         chk(seen, 16'h0001);
         status_i = (i == 1) ? ~20'he0000 : ~(20'h00001 << BI[i]);
         free_value_i = 1'b0;
         @(negedge ref_clk_i);
         chk(seen, 16'h0000);
      end
      ce_i = 1'b0;
      status_i = '1;
      @(negedge ref_clk_i);
      chk(seen, 16'h0000);
      ce_i = 1'b1;
      @(negedge ref_clk_i);
      chk(seen, 16'h0001);
      // Mid-run reset stands for a power loss: stored code goes back too
      srst_i = 1'b1;
      repeat (2) @(negedge ref_clk_i);
      srst_i = 1'b0;
      chk(active_code_o, 16'h0002);
      acc(1'b0, AD, 16'h0000, 1'b0);
      chk(rsp_o.rdata, 16'h0002);
      give_verdict;
   end
endmodule
